// [rtl/oscillator_control_map.svh]
// Register offsets, field positions, reset values and timing counts of the oscillator control.
`ifndef OSCILLATOR_CONTROL_MAP_SVH
`define OSCILLATOR_CONTROL_MAP_SVH
`define INT_OSC_MODE_ADDR      16'hFFA0
`define MAIN_OSC_CTRL_ADDR     16'hFFA2
`define INT_OSC_MODE_RESET     8'h00
`define INT_OSC_MODE_STABLE    8'h80
`define MAIN_OSC_CTRL_RESET    8'h80
`define HS_STABLE_BIT          7
`define LS_HALT_BIT            1
`define HS_HALT_BIT            0
`define MAIN_HALT_BIT          7
`define HS_SETTLE_TIME_NS      1000
`define HS_SETTLE_CYCLES       ((`HS_SETTLE_TIME_NS + 24) / 25)
`endif

// [rtl/oscillator_control_pkg.sv]
// Types shared by the oscillator control logic.
package oscillator_control_pkg;
   typedef enum logic [2:0]
   {
      PIN_IO       = 3'h1,
      PIN_CRYSTAL  = 3'h2,
      PIN_EXTERNAL = 3'h4
   } pin_mode_t;
endpackage : oscillator_control_pkg

// [rtl/oscillator_control.sv]
// Oscillator control registers and clock pin mode decoding.
`timescale 1ns/1ps
`include "oscillator_control_map.svh"
// Overview of operation
// - Subclock pins: I/O for 000/010, crystal 001 or force=1, external 011.
// - Internal oscillator register reads 00H after reset, becomes 80H once stable.
// - Bit 7 is read-only stabilization status; writes ignore it.
// - Bit 1 halts the low-speed internal oscillator when 1.
// - Bit 0 halts the high-speed internal oscillator when 1.
// - Main halt bit 7 stops crystal or blocks external main clock when 1.
// - Peripherals stop without their clock and need reinitialising afterwards.
// - Both registers accept single-bit and whole-byte writes.
// - main_clock_status reads 0 on internal oscillator, 1 on high-speed clock.
// - Main pins: I/O if select 0, crystal ext 0 select 1, external both 1.
module oscillator_control
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // CPU register access.
   input  wire logic [15:0] addr,
   input  wire logic        wr_byte,
   input  wire logic        wr_bit,
   input  wire logic [2:0]  bit_index,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   // Mode bits held in neighbouring registers.
   input  wire logic        subclock_osc_force,
   input  wire logic        subclock_external_select,
   input  wire logic        subclock_pin_select,
   input  wire logic        main_external_clock,
   input  wire logic        main_pin_select,
   input  wire logic        main_clock_select,
   // Oscillator readiness from the analog macro.
   input  wire logic        hs_osc_ready,
   // Oscillator and pin controls.
   output logic             hs_osc_run,
   output logic             ls_osc_run,
   output logic             main_osc_run,
   output logic             main_clock_status,
   output logic [2:0]       subclock_pin_mode,
   output logic [2:0]       main_pin_mode
);

   // ********************************************************************
   // Register state.
   // ********************************************************************
   typedef struct packed
   {
      logic        ready_s1;
      logic        ready_s2;
      logic [15:0] settle;
      logic        hs_stable;
      logic        ls_halt;
      logic        hs_halt;
      logic        main_halt;
      logic        hs_run;
      logic        ls_run;
      logic        main_run;
      logic        clk_status;
      logic [7:0]  rdata;
      logic [2:0]  sub_mode;
      logic [2:0]  main_mode;
   } state_t;

   // Reset image of the main control register; only its halt bit is stored.
   localparam logic [7:0] main_ctrl_reset = `MAIN_OSC_CTRL_RESET;

   state_t     s_q;
   state_t     s_d;
   logic [7:0] int_mode_val;
   logic [7:0] main_ctrl_val;
   logic [7:0] int_mode_new;
   logic [7:0] main_ctrl_new;

   // ********************************************************************
   // Next-state logic.
   // ********************************************************************
   always_comb
   begin
      s_d = s_q;
      s_d.ready_s1   = hs_osc_ready;
      s_d.ready_s2   = s_q.ready_s1;
      s_d.clk_status = main_clock_select;
      int_mode_val  = {s_q.hs_stable, 5'h00, s_q.ls_halt, s_q.hs_halt};
      main_ctrl_val = {s_q.main_halt, 7'h00};
      int_mode_new  = int_mode_val;
      main_ctrl_new = main_ctrl_val;
      // Whole-byte or single-bit write merge.
      if (wr_byte)
      begin
         int_mode_new  = wdata;
         main_ctrl_new = wdata;
      end
      else if (wr_bit)
      begin
         int_mode_new[bit_index]  = wdata[0];
         main_ctrl_new[bit_index] = wdata[0];
      end
      if ((wr_byte || wr_bit) && addr == `INT_OSC_MODE_ADDR)
      begin
         s_d.ls_halt = int_mode_new[`LS_HALT_BIT];
         s_d.hs_halt = int_mode_new[`HS_HALT_BIT];
      end
      else if ((wr_byte || wr_bit) && addr == `MAIN_OSC_CTRL_ADDR)
      begin
         s_d.main_halt = main_ctrl_new[`MAIN_HALT_BIT];
      end
      // Run levels are kept in flops so that every output leaves a register.
      s_d.hs_run   = !s_d.hs_halt;
      s_d.ls_run   = !s_d.ls_halt;
      s_d.main_run = !s_d.main_halt;
      // Stabilization status counts settle time while the oscillator runs and its synchronized readiness is high.
      if (s_q.hs_halt || !s_q.ready_s2)
      begin
         s_d.settle    = 16'h0000;
         s_d.hs_stable = 1'h0;
      end
      else if (s_q.settle < 16'(`HS_SETTLE_CYCLES))
      begin
         s_d.settle = s_q.settle + 16'h0001;
      end
      else
      begin
         s_d.hs_stable = 1'h1;
      end
      // Read data is registered and follows the address one cycle later.
      if (addr == `INT_OSC_MODE_ADDR)
         s_d.rdata = int_mode_val;
      else if (addr == `MAIN_OSC_CTRL_ADDR)
         s_d.rdata = main_ctrl_val;
      else
         s_d.rdata = 8'h00;
      // Subsystem clock pin mode.
      if (subclock_osc_force || (!subclock_external_select && subclock_pin_select))
         s_d.sub_mode = oscillator_control_pkg::PIN_CRYSTAL;
      else if (subclock_external_select && subclock_pin_select)
         s_d.sub_mode = oscillator_control_pkg::PIN_EXTERNAL;
      else
         s_d.sub_mode = oscillator_control_pkg::PIN_IO;
      // Main clock pin mode.
      if (!main_pin_select)
         s_d.main_mode = oscillator_control_pkg::PIN_IO;
      else if (main_external_clock)
         s_d.main_mode = oscillator_control_pkg::PIN_EXTERNAL;
      else
         s_d.main_mode = oscillator_control_pkg::PIN_CRYSTAL;
   end

   // ********************************************************************
   // State register.
   // ********************************************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_q           <= '0;
         s_q.main_halt <= main_ctrl_reset[`MAIN_HALT_BIT];
         s_q.hs_run    <= 1'h1;
         s_q.ls_run    <= 1'h1;
         s_q.main_run  <= !main_ctrl_reset[`MAIN_HALT_BIT];
         s_q.sub_mode  <= oscillator_control_pkg::PIN_IO;
         s_q.main_mode <= oscillator_control_pkg::PIN_IO;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ********************************************************************
   // Outputs.
   // ********************************************************************
   assign rdata             = s_q.rdata;
   assign hs_osc_run        = s_q.hs_run;
   assign ls_osc_run        = s_q.ls_run;
   assign main_osc_run      = s_q.main_run;
   assign main_clock_status = s_q.clk_status;
   assign subclock_pin_mode = s_q.sub_mode;
   assign main_pin_mode     = s_q.main_mode;

   // ********************************************************************
   // Checks.
   // ********************************************************************
   chk_status_write_proof: assert property (@(posedge clock) disable iff (rst)
      (wr_byte || wr_bit) && addr == `INT_OSC_MODE_ADDR && s_q.hs_stable && !s_q.hs_halt && s_q.ready_s2
      |=> s_q.hs_stable)
      else $error("Write changed the stabilization status.");
   chk_halt_clears_stable: assert property (@(posedge clock) disable iff (rst)
      s_q.hs_halt |=> !s_q.hs_stable)
      else $error("Stable flag kept while high-speed oscillator halted.");
   chk_stable_needs_run: assert property (@(posedge clock) disable iff (rst)
      s_q.hs_stable |-> $past(!s_q.hs_halt))
      else $error("Stable flag set while high-speed oscillator halted.");
   chk_stable_reads_top: assert property (@(posedge clock) disable iff (rst)
      $past(addr) == `INT_OSC_MODE_ADDR && $past(s_q.hs_stable) |-> rdata[7])
      else $error("Stable status not reflected in read data.");
   chk_unused_zero: assert property (@(posedge clock) disable iff (rst)
      $past(addr) == `INT_OSC_MODE_ADDR |-> rdata[6:2] == 5'h00)
      else $error("Unused bits read nonzero.");
   chk_main_halt_write: assert property (@(posedge clock) disable iff (rst)
      wr_byte && addr == `MAIN_OSC_CTRL_ADDR |=> main_osc_run == !$past(wdata[7]))
      else $error("Main halt byte write not applied.");
   chk_hs_bit_write: assert property (@(posedge clock) disable iff (rst)
      wr_bit && !wr_byte && addr == `INT_OSC_MODE_ADDR && bit_index == 3'h0 |=> hs_osc_run == !$past(wdata[0]))
      else $error("High-speed halt bit write not applied.");
   chk_ls_byte_write: assert property (@(posedge clock) disable iff (rst)
      wr_byte && addr == `INT_OSC_MODE_ADDR |=> ls_osc_run == !$past(wdata[1]))
      else $error("Low-speed halt byte write not applied.");
   chk_sub_force: assert property (@(posedge clock) disable iff (rst)
      subclock_osc_force |=> subclock_pin_mode == oscillator_control_pkg::PIN_CRYSTAL)
      else $error("Forced subclock not crystal mode.");
   chk_main_io: assert property (@(posedge clock) disable iff (rst)
      !main_pin_select |=> main_pin_mode == oscillator_control_pkg::PIN_IO)
      else $error("Main pins not in I/O mode.");
   chk_status_follow: assert property (@(posedge clock) disable iff (rst)
      main_clock_select |=> main_clock_status)
      else $error("Main clock status not following selection.");

endmodule : oscillator_control

// [dv/test_oscillator_control.sv]
// Self-checking testbench of the oscillator control registers and clock pin mode decoding.
`timescale 1ns/1ps
`include "oscillator_control_map.svh"
module test_oscillator_control;
   logic        clock = 1'h0;
   logic        rst = 1'h1;
   logic [15:0] addr = 16'h0000;
   logic        wr_byte = 1'h0;
   logic        wr_bit = 1'h0;
   logic [2:0]  bit_index = 3'h0;
   logic [7:0]  wdata = 8'h00;
   logic [2:0]  sub_sel = 3'h0;
   logic [1:0]  main_sel = 2'h0;
   logic        main_clock_select = 1'h0;
   logic        hs_osc_ready = 1'h1;
   logic [7:0]  rdata;
   logic        hs_osc_run, ls_osc_run, main_osc_run, main_clock_status;
   logic [2:0]  subclock_pin_mode, main_pin_mode;
   logic [2:0]  exp_sub, exp_main;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #12.5 clock = ~clock;

   oscillator_control dut (.clock(clock), .rst(rst), .addr(addr), .wr_byte(wr_byte), .wr_bit(wr_bit),
      .bit_index(bit_index), .wdata(wdata), .rdata(rdata), .subclock_osc_force(sub_sel[2]),
      .subclock_external_select(sub_sel[1]), .subclock_pin_select(sub_sel[0]),
      .main_external_clock(main_sel[1]), .main_pin_select(main_sel[0]), .main_clock_select(main_clock_select),
      .hs_osc_ready(hs_osc_ready), .hs_osc_run(hs_osc_run), .ls_osc_run(ls_osc_run),
      .main_osc_run(main_osc_run), .main_clock_status(main_clock_status),
      .subclock_pin_mode(subclock_pin_mode), .main_pin_mode(main_pin_mode));

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic write_reg(input logic [15:0] a, input logic [7:0] d, input logic one_bit, input logic [2:0] idx);
      addr = a;
      wdata = d;
      wr_byte = !one_bit;
      wr_bit = one_bit;
      bit_index = idx;
      @(posedge clock);
      #1;
      wr_byte = 1'h0;
      wr_bit = 1'h0;
      @(posedge clock);
      #1;
   endtask : write_reg

   task automatic read_reg(input logic [15:0] a, input logic [7:0] exp, input string what);
      addr = a;
      @(posedge clock);
      #1;
      check(rdata, exp, what);
   endtask : read_reg

   task automatic wait_stable(input string what);
      addr = `INT_OSC_MODE_ADDR;
      for (int i = 0; i < 100 && rdata !== `INT_OSC_MODE_STABLE; i++)
      begin
         @(posedge clock);
         #1;
      end
      check(rdata, `INT_OSC_MODE_STABLE, what);
   endtask : wait_stable

   task automatic test_reset();
      read_reg(`INT_OSC_MODE_ADDR, `INT_OSC_MODE_RESET, "internal mode after reset");
      read_reg(`MAIN_OSC_CTRL_ADDR, `MAIN_OSC_CTRL_RESET, "main control after reset");
      check({5'h00, hs_osc_run, ls_osc_run, main_osc_run}, 8'h06, "run levels after reset");
      wait_stable("stable status");
      hs_osc_ready = 1'h0;
      repeat (4) @(posedge clock);
      #1;
      check(rdata, `INT_OSC_MODE_RESET, "stable cleared by lost readiness");
      hs_osc_ready = 1'h1;
      wait_stable("stable status regained");
      $display("test_reset done");
   endtask : test_reset

   task automatic test_internal();
      main_clock_select = 1'h1;
      write_reg(`INT_OSC_MODE_ADDR, 8'h7E, 1'h0, 3'h0);
      read_reg(`INT_OSC_MODE_ADDR, 8'h82, "internal mode byte write");
      check({6'h00, hs_osc_run, ls_osc_run}, 8'h02, "low-speed halted");
      write_reg(`INT_OSC_MODE_ADDR, 8'h01, 1'h1, 3'h0);
      check({6'h00, hs_osc_run, ls_osc_run}, 8'h00, "high-speed halted by bit write");
      read_reg(`INT_OSC_MODE_ADDR, 8'h03, "stable cleared by halt");
      write_reg(`INT_OSC_MODE_ADDR, 8'h00, 1'h0, 3'h0);
      check({6'h00, hs_osc_run, ls_osc_run}, 8'h03, "both oscillators run");
      $display("test_internal done");
   endtask : test_internal

   task automatic test_main();
      main_clock_select = 1'h0;
      main_sel = 2'h1;
      write_reg(`MAIN_OSC_CTRL_ADDR, 8'h00, 1'h0, 3'h0);
      check({7'h00, main_osc_run}, 8'h01, "main oscillator runs");
      write_reg(`MAIN_OSC_CTRL_ADDR, 8'h01, 1'h1, 3'h7);
      check({7'h00, main_osc_run}, 8'h00, "main halted by bit write");
      read_reg(`MAIN_OSC_CTRL_ADDR, 8'h80, "main control after bit write");
      write_reg(`MAIN_OSC_CTRL_ADDR, 8'h7F, 1'h0, 3'h0);
      read_reg(`MAIN_OSC_CTRL_ADDR, 8'h00, "main control unused bits");
      write_reg(16'hFFA1, 8'hFF, 1'h0, 3'h0);
      read_reg(16'hFFA1, 8'h00, "unmapped address");
      read_reg(`MAIN_OSC_CTRL_ADDR, 8'h00, "main control after unmapped write");
      write_reg(`MAIN_OSC_CTRL_ADDR, 8'h80, 1'h0, 3'h0);
      read_reg(`MAIN_OSC_CTRL_ADDR, 8'h80, "main halted again");
      $display("test_main done");
   endtask : test_main

   task automatic test_pins();
      for (int i = 0; i < 8; i++)
      begin
         sub_sel = 3'(i);
         main_sel = 2'(i);
         main_clock_select = sub_sel[0];
         exp_sub = sub_sel[2] ? oscillator_control_pkg::PIN_CRYSTAL : !sub_sel[0] ? oscillator_control_pkg::PIN_IO :
            sub_sel[1] ? oscillator_control_pkg::PIN_EXTERNAL : oscillator_control_pkg::PIN_CRYSTAL;
         exp_main = !main_sel[0] ? oscillator_control_pkg::PIN_IO :
            main_sel[1] ? oscillator_control_pkg::PIN_EXTERNAL : oscillator_control_pkg::PIN_CRYSTAL;
         @(posedge clock);
         #1;
         check({1'b0, subclock_pin_mode, main_pin_mode, main_clock_status}, {1'b0, exp_sub, exp_main, sub_sel[0]},
            "pin modes and status");
      end
      $display("test_pins done");
   endtask : test_pins

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   initial
   begin
      repeat (3) @(posedge clock);
      #1;
      rst = 1'h0;
      test_reset();
      test_internal();
      test_main();
      test_pins();
      summarize();
   end

   initial
   begin
      #50000;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end
endmodule : test_oscillator_control
